// ### rtl/ccoc_pkg.sv
// Purpose: Shared constants for the clock channel output configuration block.
// Assumes: Registers are 32-bit words on Avalon-MM; byte address is four times the register index.
// Notes:   Field layouts of the channel words are placed low in the word, upper bits read as zero.
//
// Overview of operation
// R1 - Delay lags divider output, 150 ps steps.
// R2 - Delayed path adds fixed 300 ps.
// R3 - Four-bit code k gives k times 150 ps.
// R4 - Per-pin CMOS state: inverted, normal, low, off.
// R5 - Swing bit: clear 800 mVpp, set 1000 mVpp.
// R6 - Source mux: bypass, divided, delayed, both.
// R7 - Delay referenced to divider output path.
// R8 - Reserved words 5, 6, 8, 9 stay untouched.
// R9 - Soft reset restores all words, self-clears.
// R10 - Unused soft reset bit written as zero.
// R11 - Wait bit set: tune waits for lock.
// R12 - Wait bit clear: tune after counter write.
// R13 - Clearing wait bit never blocks first loop lock.
// R14 - Five identical channel words, zero to four.
// R15 - Divided path gives twice code; zero invalid.
// R16 - A channel write touches only that channel.

package ccoc_pkg;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam int unsigned NUM_CH       = 5;
	localparam int unsigned NUM_REG      = 16;
	localparam logic [4:0]  IDX_CH0      = 5'h00;
	localparam logic [4:0]  IDX_RSV_A    = 5'h05;
	localparam logic [4:0]  IDX_RSV_B    = 5'h06;
	localparam logic [4:0]  IDX_SOFT_RST = 5'h07;
	localparam logic [4:0]  IDX_RSV_C    = 5'h08;
	localparam logic [4:0]  IDX_RSV_D    = 5'h09;
	localparam logic [4:0]  IDX_TUNE_CTL = 5'h0a;
	localparam logic [4:0]  IDX_FB_CNT   = 5'h0f;
	localparam logic [4:0]  IDX_STATUS   = 5'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned DIV_LSB    = 0;
	localparam int unsigned DIV_W      = 8;
	localparam int unsigned DLY_LSB    = 8;
	localparam int unsigned DLY_W      = 4;
	localparam int unsigned MUX_LSB    = 12;
	localparam int unsigned A_ST_LSB   = 14;
	localparam int unsigned B_ST_LSB   = 16;
	localparam int unsigned PECL_BIT   = 18;
	localparam int unsigned SRST_BIT   = 0;
	localparam int unsigned WAIT_BIT   = 0;
	localparam int unsigned FB_W       = 18;
	localparam int unsigned ST_LOCK    = 0;
	localparam int unsigned ST_PEND    = 1;
	localparam int unsigned ST_INV_LSB = 2;

	// ----------------------------------------------------------------
	// Writable masks and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] CH_MASK   = 32'h0007ffff;
	localparam logic [31:0] RSV_MASK  = 32'hffffffff;
	localparam logic [31:0] TUNE_MASK = 32'h00000001;
	localparam logic [31:0] FB_MASK   = 32'h0003ffff;
	localparam logic [31:0] CH_RST    = 32'h00000001;
	localparam logic [31:0] RSV_RST   = 32'h00000000;
	localparam logic [31:0] TUNE_RST  = 32'h00000000;
	localparam logic [31:0] FB_RST    = 32'h00000001;

	// ----------------------------------------------------------------
	// Delay figures in picoseconds
	// ----------------------------------------------------------------
	localparam int unsigned PS_W       = 12;
	localparam logic [11:0] STEP_PS    = 12'h096;
	localparam logic [11:0] FIXED_PS   = 12'h12c;
	localparam logic [11:0] MAX_DLY_PS = 12'h8ca;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_BYPASS  = 2'b00,
		SRC_DIVIDED = 2'b01,
		SRC_DELAYED = 2'b10,
		SRC_DIV_DLY = 2'b11
	} ccoc_src_t;

	typedef enum logic [1:0] {
		PIN_INVERTED = 2'b00,
		PIN_NORMAL   = 2'b01,
		PIN_LOW      = 2'b10,
		PIN_OFF      = 2'b11
	} ccoc_pin_t;

	typedef enum logic [1:0] {
		TUNE_IDLE = 2'b00,
		TUNE_WAIT = 2'b01
	} ccoc_tune_t;

endpackage

// ### rtl/ccoc_chan_if.sv
// Purpose: Carries one channel's settings into its decoder and the decoded controls back.
// Assumes: One instance per channel.
// Notes:   No clocking block; the decoder registers its results.
`timescale 1ns/10ps
`default_nettype none

interface ccoc_chan_if;
	logic [7:0]  div_code;
	logic [3:0]  delay_code;
	logic [1:0]  source_sel;
	logic [1:0]  pin_a_state;
	logic [1:0]  pin_b_state;
	logic [11:0] delay_ps;
	logic [8:0]  total_div;
	logic        div_invalid;
	logic [1:0]  pin_oe;
	logic [1:0]  pin_inv;
	logic [1:0]  pin_low;

	modport cfg  (output div_code, delay_code, source_sel, pin_a_state, pin_b_state,
	              input delay_ps, total_div, div_invalid, pin_oe, pin_inv, pin_low);
	modport chan (input div_code, delay_code, source_sel, pin_a_state, pin_b_state,
	              output delay_ps, total_div, div_invalid, pin_oe, pin_inv, pin_low);
endinterface

`default_nettype wire

// ### rtl/ccoc_channel.sv
// Purpose: Decodes one channel's settings into delay, divide and pin controls.
// Assumes: Settings come from flops on the same clock.
// Notes:   Results appear one clock after a settings change.
`timescale 1ns/10ps
`default_nettype none

module ccoc_channel (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	ccoc_chan_if.chan ch
);

	logic [11:0] delay_ps_r,    delay_ps_nxt;
	logic [8:0]  total_div_r,   total_div_nxt;
	logic        div_invalid_r, div_invalid_nxt;
	logic [1:0]  pin_oe_r,      pin_oe_nxt;
	logic [1:0]  pin_inv_r,     pin_inv_nxt;
	logic [1:0]  pin_low_r,     pin_low_nxt;

	// Returns output enable, invert and force-low for one pin state code.
	function automatic logic [2:0] pin_decode(input logic [1:0] st);
		logic [2:0] r;
		r = 3'h0;
		unique case (st)
			ccoc_pkg::PIN_INVERTED: r = 3'h3;
			ccoc_pkg::PIN_NORMAL:   r = 3'h1;
			ccoc_pkg::PIN_LOW:      r = 3'h5;
			ccoc_pkg::PIN_OFF:      r = 3'h0;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------

	// The delay stage sits after the divider, so its lag counts from the divider output.
	always_comb begin
		logic [2:0] a;
		logic [2:0] b;
		a = pin_decode(ch.pin_a_state); // R4
		b = pin_decode(ch.pin_b_state); // R4
		delay_ps_nxt = 12'h000;
		if (ch.source_sel[1]) begin // R6 R7
			delay_ps_nxt = ccoc_pkg::FIXED_PS + ({8'h00, ch.delay_code} * ccoc_pkg::STEP_PS); // R1 R2 R3
		end
		total_div_nxt   = ch.source_sel[0] ? {ch.div_code, 1'b0} : 9'h001; // R6 R15
		div_invalid_nxt = ch.source_sel[0] && (ch.div_code == 8'h00); // R15
		pin_oe_nxt      = {b[0], a[0]};
		pin_inv_nxt     = {b[1], a[1]};
		pin_low_nxt     = {b[2], a[2]};
	end

	// Holds the decoded controls.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			delay_ps_r    <= 12'h000;
			total_div_r   <= 9'h001;
			div_invalid_r <= 1'b0;
			pin_oe_r      <= 2'h0;
			pin_inv_r     <= 2'h0;
			pin_low_r     <= 2'h0;
		end else begin
			delay_ps_r    <= delay_ps_nxt;
			total_div_r   <= total_div_nxt;
			div_invalid_r <= div_invalid_nxt;
			pin_oe_r      <= pin_oe_nxt;
			pin_inv_r     <= pin_inv_nxt;
			pin_low_r     <= pin_low_nxt;
		end
	end

	assign ch.delay_ps    = delay_ps_r;
	assign ch.total_div   = total_div_r;
	assign ch.div_invalid = div_invalid_r;
	assign ch.pin_oe      = pin_oe_r;
	assign ch.pin_inv     = pin_inv_r;
	assign ch.pin_low     = pin_low_r;

endmodule

`default_nettype wire

// ### rtl/ccoc_top.sv
// Purpose: Register bank for five clock output channels and the VCO tuning trigger.
// Assumes: Avalon-MM slave, byte addresses, 32-bit words; lock input is asynchronous.
// Notes:   Every request waits one cycle, then waitrequest drops for one cycle.
`timescale 1ns/10ps
`default_nettype none

module ccoc_top (
	input  wire logic        REF_CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic [6:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	input  wire logic        PLL1_LOCK_I,
	output logic      [39:0] CH_DIVIDE_CODE_O,
	output logic      [19:0] CH_DELAY_CODE_O,
	output logic      [9:0]  CH_SOURCE_SEL_O,
	output logic      [4:0]  PECL_SWING_SELECT_O,
	output logic      [59:0] CH_DELAY_PS_O,
	output logic      [44:0] CH_TOTAL_DIV_O,
	output logic      [9:0]  CMOS_PIN_OE_O,
	output logic      [9:0]  CMOS_PIN_INV_O,
	output logic      [9:0]  CMOS_PIN_LOW_O,
	output logic      [17:0] FB_COUNTER_O,
	output logic             TUNE_START_O
);

	// ----------------------------------------------------------------
	// Register storage and helpers
	// ----------------------------------------------------------------

	logic [31:0] reg_r   [0:15];
	logic [31:0] reg_nxt [0:15];
	logic        wait_r,  wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        sync1_r, sync2_r, sync3_r;
	logic        lock_r,  lock_nxt;
	ccoc_pkg::ccoc_tune_t tune_r, tune_nxt;
	logic        pulse_r, pulse_nxt;
	logic [4:0]  idx;
	logic        accept;
	logic        wr_acc;
	logic        soft_rst;
	logic        fb_write;
	logic [31:0] be_mask;
	logic [4:0]  div_inv;
	logic [31:0] status;

	// Writable bits of each word; unmapped and write-only words give zero.
	function automatic logic [31:0] fld_mask(input logic [4:0] i);
		logic [31:0] m;
		m = 32'h0;
		if (i < 5'(ccoc_pkg::NUM_CH)) begin // R14
			m = ccoc_pkg::CH_MASK;
		end else if (i == ccoc_pkg::IDX_RSV_A || i == ccoc_pkg::IDX_RSV_B ||
		             i == ccoc_pkg::IDX_RSV_C || i == ccoc_pkg::IDX_RSV_D) begin // R8
			m = ccoc_pkg::RSV_MASK;
		end else if (i == ccoc_pkg::IDX_TUNE_CTL) begin
			m = ccoc_pkg::TUNE_MASK;
		end else if (i == ccoc_pkg::IDX_FB_CNT) begin
			m = ccoc_pkg::FB_MASK;
		end
		return m;
	endfunction

	// Power-on value of each word.
	function automatic logic [31:0] rst_val(input logic [4:0] i);
		logic [31:0] v;
		v = 32'h0;
		if (i < 5'(ccoc_pkg::NUM_CH)) begin
			v = ccoc_pkg::CH_RST;
		end else if (i == ccoc_pkg::IDX_TUNE_CTL) begin
			v = ccoc_pkg::TUNE_RST;
		end else if (i == ccoc_pkg::IDX_FB_CNT) begin
			v = ccoc_pkg::FB_RST;
		end else if (fld_mask(i) != 32'h0) begin
			v = ccoc_pkg::RSV_RST;
		end
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------

	// A request is taken only in the cycle its waitrequest is low.
	always_comb begin
		idx      = AVS_ADDRESS_I[6:2];
		accept   = (AVS_READ_I || AVS_WRITE_I) && !wait_r;
		wr_acc   = accept && AVS_WRITE_I;
		be_mask  = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
		            {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
		soft_rst = wr_acc && (idx == ccoc_pkg::IDX_SOFT_RST) && AVS_BYTEENABLE_I[0] &&
		           AVS_WRITEDATA_I[ccoc_pkg::SRST_BIT];                              // R9
		fb_write = wr_acc && (idx == ccoc_pkg::IDX_FB_CNT) &&
		           ((be_mask & ccoc_pkg::FB_MASK) != 32'h0);
	end

	// Status word: lock, tune pending and per-channel invalid divide.
	always_comb begin
		status = 32'h0;
		status[ccoc_pkg::ST_LOCK] = lock_r;
		status[ccoc_pkg::ST_PEND] = (tune_r == ccoc_pkg::TUNE_WAIT);
		status[ccoc_pkg::ST_INV_LSB +: 5] = div_inv;
	end

	// Waitrequest drops for one cycle after each fresh request; read data is
	// latched at the same edge so it stands while waitrequest is low.
	always_comb begin
		wait_nxt  = !((AVS_READ_I || AVS_WRITE_I) && wait_r);
		rdata_nxt = rdata_r;
		if (AVS_READ_I && wait_r) begin
			if (idx == ccoc_pkg::IDX_STATUS) begin
				rdata_nxt = status;
			end else if (idx < 5'(ccoc_pkg::NUM_REG)) begin
				rdata_nxt = reg_r[idx[3:0]] & fld_mask(idx);
			end else begin
				rdata_nxt = 32'h0;
			end
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0;
		end else begin
			wait_r  <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------

	// Only the addressed word changes, so a channel write leaves the others alone.
	// The soft reset bit is not stored, which is how it clears itself.
	always_comb begin
		for (int i = 0; i < ccoc_pkg::NUM_REG; i++) begin
			reg_nxt[i] = reg_r[i];
			if (soft_rst) begin
				reg_nxt[i] = rst_val(5'(i)); // R9
			end else if (wr_acc && idx == 5'(i)) begin // R16
				reg_nxt[i] = (reg_r[i] & ~(fld_mask(idx) & be_mask)) |
				             (AVS_WRITEDATA_I & fld_mask(idx) & be_mask);
			end
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			for (int i = 0; i < ccoc_pkg::NUM_REG; i++) begin
				reg_r[i] <= rst_val(5'(i));
			end
		end else begin
			for (int i = 0; i < ccoc_pkg::NUM_REG; i++) begin
				reg_r[i] <= reg_nxt[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Lock input synchroniser
	// ----------------------------------------------------------------

	// The lock level is only observed, never gated, so the first loop keeps
	// locking on its own whatever the wait bit holds.
	always_comb begin
		lock_nxt = (sync2_r == sync3_r) ? sync3_r : lock_r; // R13
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
			lock_r  <= 1'b0;
		end else begin
			sync1_r <= PLL1_LOCK_I;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			lock_r  <= lock_nxt;
		end
	end

	// ----------------------------------------------------------------
	// VCO tuning trigger
	// ----------------------------------------------------------------

	// A feedback counter write either fires at once or parks until lock.
	// Clearing the wait bit while parked releases the trigger.
	always_comb begin
		tune_nxt  = tune_r;
		pulse_nxt = 1'b0;
		unique case (tune_r)
			ccoc_pkg::TUNE_IDLE: begin
				if (fb_write) begin
					if (reg_r[ccoc_pkg::IDX_TUNE_CTL[3:0]][ccoc_pkg::WAIT_BIT]) begin
						tune_nxt = ccoc_pkg::TUNE_WAIT; // R11
					end else begin
						pulse_nxt = 1'b1; // R12
					end
				end
			end
			ccoc_pkg::TUNE_WAIT: begin
				if (lock_r || !reg_r[ccoc_pkg::IDX_TUNE_CTL[3:0]][ccoc_pkg::WAIT_BIT]) begin
					tune_nxt  = ccoc_pkg::TUNE_IDLE; // R11
					pulse_nxt = 1'b1;
				end
			end
			default: begin
				tune_nxt = ccoc_pkg::TUNE_IDLE;
			end
		endcase
		if (soft_rst) begin
			tune_nxt  = ccoc_pkg::TUNE_IDLE;
			pulse_nxt = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			tune_r  <= ccoc_pkg::TUNE_IDLE;
			pulse_r <= 1'b0;
		end else begin
			tune_r  <= tune_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------

	// Each channel word feeds its own decoder; raw fields leave straight from storage.
	for (genvar g = 0; g < ccoc_pkg::NUM_CH; g++) begin : g_ch
		ccoc_chan_if ch_if ();

		assign ch_if.div_code    = reg_r[g][ccoc_pkg::DIV_LSB +: 8];
		assign ch_if.delay_code  = reg_r[g][ccoc_pkg::DLY_LSB +: 4];
		assign ch_if.source_sel  = reg_r[g][ccoc_pkg::MUX_LSB +: 2];
		assign ch_if.pin_a_state = reg_r[g][ccoc_pkg::A_ST_LSB +: 2];
		assign ch_if.pin_b_state = reg_r[g][ccoc_pkg::B_ST_LSB +: 2];

		ccoc_channel u_ch (
			.clk_i   (REF_CLK_I),
			.rst_n_i (RESETN_I),
			.ch      (ch_if.chan)
		);

		assign CH_DIVIDE_CODE_O[g*8 +: 8]  = reg_r[g][ccoc_pkg::DIV_LSB +: 8];
		assign CH_DELAY_CODE_O[g*4 +: 4]   = reg_r[g][ccoc_pkg::DLY_LSB +: 4];
		assign CH_SOURCE_SEL_O[g*2 +: 2]   = reg_r[g][ccoc_pkg::MUX_LSB +: 2];
		assign PECL_SWING_SELECT_O[g]      = reg_r[g][ccoc_pkg::PECL_BIT]; // R5
		assign CH_DELAY_PS_O[g*12 +: 12]   = ch_if.delay_ps;
		assign CH_TOTAL_DIV_O[g*9 +: 9]    = ch_if.total_div;
		assign CMOS_PIN_OE_O[g*2 +: 2]     = ch_if.pin_oe;
		assign CMOS_PIN_INV_O[g*2 +: 2]    = ch_if.pin_inv;
		assign CMOS_PIN_LOW_O[g*2 +: 2]    = ch_if.pin_low;
		assign div_inv[g]                  = ch_if.div_invalid;
	end

	// ----------------------------------------------------------------
	// Remaining outputs
	// ----------------------------------------------------------------

	assign AVS_READDATA_O    = rdata_r;
	assign AVS_WAITREQUEST_O = wait_r;
	assign FB_COUNTER_O      = reg_r[ccoc_pkg::IDX_FB_CNT[3:0]][17:0];
	assign TUNE_START_O      = pulse_r;

endmodule

`default_nettype wire

// ### bench/ccoc_properties.sv
// Purpose: Port-level assertions for the channel configuration register bank.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Expected decodes come from registered copies of the field outputs.
`timescale 1ns/10ps
`default_nettype none

module ccoc_properties (
	input wire logic        REF_CLK_I,
	input wire logic        RESETN_I,
	input wire logic [6:0]  AVS_ADDRESS_I,
	input wire logic        AVS_READ_I,
	input wire logic        AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0]  AVS_BYTEENABLE_I,
	input wire logic        AVS_WAITREQUEST_O,
	input wire logic        PLL1_LOCK_I,
	input wire logic [39:0] CH_DIVIDE_CODE_O,
	input wire logic [19:0] CH_DELAY_CODE_O,
	input wire logic [9:0]  CH_SOURCE_SEL_O,
	input wire logic [4:0]  PECL_SWING_SELECT_O,
	input wire logic [59:0] CH_DELAY_PS_O,
	input wire logic [44:0] CH_TOTAL_DIV_O,
	input wire logic [9:0]  CMOS_PIN_OE_O,
	input wire logic [9:0]  CMOS_PIN_INV_O,
	input wire logic [9:0]  CMOS_PIN_LOW_O,
	input wire logic        TUNE_START_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RESETN_I);
	logic        wr_ok;
	logic        wait_nxt, wait_r;
	logic [59:0] ps_nxt, ps_r;
	logic [44:0] div_nxt, div_r;

	// A write lands only at the edge where waitrequest is low.
	assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O;

	// Track the wait-for-lock bit and decode the fields as the paths must see them.
	always_comb begin
		wait_nxt = wait_r;
		if (wr_ok && AVS_ADDRESS_I[6:2] == ccoc_pkg::IDX_TUNE_CTL && AVS_BYTEENABLE_I[0]) begin
			wait_nxt = AVS_WRITEDATA_I[0];
		end
		if (wr_ok && AVS_ADDRESS_I[6:2] == ccoc_pkg::IDX_SOFT_RST && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[0]) begin
			wait_nxt = 1'b0;
		end
		for (int g = 0; g < 5; g++) begin
			ps_nxt[12*g +: 12] = CH_SOURCE_SEL_O[2*g+1] ? 12'h12c + 12'h096 * CH_DELAY_CODE_O[4*g +: 4] : 12'h000;
			div_nxt[9*g +: 9]  = CH_SOURCE_SEL_O[2*g] ? {CH_DIVIDE_CODE_O[8*g +: 8], 1'b0} : 9'h001;
		end
	end

	// Reset copies match the design's reset outputs, so no edge after release misfires.
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			wait_r <= 1'b0;
			ps_r   <= '0;
			div_r  <= {5{9'h001}};
		end else begin
			wait_r <= wait_nxt;
			ps_r   <= ps_nxt;
			div_r  <= div_nxt;
		end
	end

	sequence s_req_start;
		$rose(AVS_READ_I || AVS_WRITE_I);
	endsequence
	sequence s_fb_accept;
		wr_ok && AVS_ADDRESS_I[6:2] == ccoc_pkg::IDX_FB_CNT && (|AVS_BYTEENABLE_I[2:0]);
	endsequence

	a_one_wait_cycle: assert property (s_req_start |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
		else $error("waitrequest did not drop after one wait cycle");
	a_wait_low_once: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
		else $error("waitrequest stayed low");
	a_delay_decode: assert property (CH_DELAY_PS_O == ps_r)
		else $error("channel delay does not follow code");
	a_divide_decode: assert property (CH_TOTAL_DIV_O == div_r)
		else $error("channel divide does not follow code");
	a_pin_exclusive: assert property (((CMOS_PIN_INV_O & CMOS_PIN_LOW_O) == 10'h000)
		&& (((CMOS_PIN_INV_O | CMOS_PIN_LOW_O) & ~CMOS_PIN_OE_O) == 10'h000))
		else $error("pin controls contradict");
	a_tune_one_pulse: assert property (TUNE_START_O |=> !TUNE_START_O)
		else $error("tune start wider than one cycle");
	a_tune_at_once: assert property (s_fb_accept ##0 !wait_r |=> TUNE_START_O)
		else $error("tune start missing after counter write");
	a_tune_held_off: assert property ((wait_r && !PLL1_LOCK_I) [*8] |-> !TUNE_START_O)
		else $error("tune started without lock");
	a_fields_hold: assert property (!wr_ok |=> $stable(CH_DIVIDE_CODE_O) && $stable(CH_DELAY_CODE_O)
		&& $stable(CH_SOURCE_SEL_O) && $stable(PECL_SWING_SELECT_O))
		else $error("channel field changed without a write");
endmodule

bind ccoc_top ccoc_properties ccoc_properties_i (.REF_CLK_I, .RESETN_I, .AVS_ADDRESS_I, .AVS_READ_I,
	.AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_WAITREQUEST_O, .PLL1_LOCK_I,
	.CH_DIVIDE_CODE_O, .CH_DELAY_CODE_O, .CH_SOURCE_SEL_O, .PECL_SWING_SELECT_O, .CH_DELAY_PS_O,
	.CH_TOTAL_DIV_O, .CMOS_PIN_OE_O, .CMOS_PIN_INV_O, .CMOS_PIN_LOW_O, .TUNE_START_O);

`default_nettype wire

// ### bench/ccoc_host.sv
// Purpose: Programming controller model that masters the register bus.
// Assumes: Called from one process; signals move only just after a rising edge.
// Notes:   The wait for waitrequest is unbounded here; the bench watchdog ends a hang.
`timescale 1ns/10ps
`default_nettype none

module ccoc_host (
	input  wire logic        clk_i,
	input  wire logic        waitrequest_i,
	input  wire logic [31:0] readdata_i,
	output logic      [6:0]  address_o,
	output logic             read_o,
	output logic             write_o,
	output logic      [31:0] writedata_o,
	output logic      [3:0]  byteenable_o
);
	// Idle bus from time zero.
	initial begin
		address_o    = 7'h00;
		read_o       = 1'b0;
		write_o      = 1'b0;
		writedata_o  = 32'h00000000;
		byteenable_o = 4'h0;
	end

	// One access, held until waitrequest is sampled low, released at that same edge.
	task automatic access(input logic we, input logic [4:0] idx, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] rd);
		rd = 32'h00000000;
		if (we && (idx == 5'h05 || idx == 5'h06 || idx == 5'h08 || idx == 5'h09)) begin
			return;
		end
		@(posedge clk_i);
		address_o    <= {idx, 2'b00};
		read_o       <= !we;
		write_o      <= we;
		writedata_o  <= d;
		byteenable_o <= be;
		do @(posedge clk_i); while (waitrequest_i !== 1'b0);
		rd = readdata_i;
		read_o  <= 1'b0;
		write_o <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ### bench/tb.sv
// Purpose: Self-checking bench for the channel configuration register bank.
// Assumes: 40 MHz clock; a shadow model of the words predicts the results of every check_all.
// Notes:   Random data comes from a 16-bit shift register seeded at 50974.
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic        clk = 1'b0, rst_n = 1'b0, lock = 1'b0;
	logic [6:0]  addr;
	logic        rd_en, wr_en, waitreq, tune;
	logic [31:0] wdata, rdata, r;
	logic [3:0]  be;
	logic [39:0] div_c;
	logic [19:0] dly_c;
	logic [9:0]  src, oe, inv, low;
	logic [4:0]  swing;
	logic [59:0] ps;
	logic [44:0] tdiv;
	logic [17:0] fb;
	logic [15:0] lf = 16'hc71e;
	int          mdl [0:16];
	int          mismatches = 0, n_tests = 0, tunes = 0, t0;

	// Clock at 25 ns period.
	always #12.5 clk = ~clk;

	ccoc_top ccoc_top_i (.REF_CLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en),
		.AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(waitreq), .PLL1_LOCK_I(lock), .CH_DIVIDE_CODE_O(div_c), .CH_DELAY_CODE_O(dly_c),
		.CH_SOURCE_SEL_O(src), .PECL_SWING_SELECT_O(swing), .CH_DELAY_PS_O(ps), .CH_TOTAL_DIV_O(tdiv),
		.CMOS_PIN_OE_O(oe), .CMOS_PIN_INV_O(inv), .CMOS_PIN_LOW_O(low), .FB_COUNTER_O(fb),
		.TUNE_START_O(tune));
	ccoc_host ccoc_host_i (.clk_i(clk), .waitrequest_i(waitreq), .readdata_i(rdata), .address_o(addr),
		.read_o(rd_en), .write_o(wr_en), .writedata_o(wdata), .byteenable_o(be));

	// Count tune pulses as sampled at each edge.
	always @(posedge clk) if (tune === 1'b1) tunes++;

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [31:0] mask(input logic [4:0] i);
		case (i)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h04: return ccoc_pkg::CH_MASK;
			5'h05, 5'h06, 5'h08, 5'h09: return ccoc_pkg::RSV_MASK;
			5'h0a: return ccoc_pkg::TUNE_MASK;
			5'h0f: return ccoc_pkg::FB_MASK;
			default: return 32'h00000000;
		endcase
	endfunction

	// Shadow words return to their power-on values.
	task automatic mdl_reset;
		for (int i = 0; i < 17; i++) mdl[i] = (i < 5) ? 1 : (i == 15) ? 1 : 0;
	endtask

	// Two shift register steps make one 32-bit random word.
	function automatic logic [31:0] nxt_rnd();
		logic [31:0] v;
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		v[15:0] = lf;
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		v[31:16] = lf;
		return v;
	endfunction

	task automatic wr(input logic [4:0] i, input logic [31:0] d, input logic [3:0] b);
		logic [31:0] bm, x;
		ccoc_host_i.access(1'b1, i, d, b, x);
		bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
		if (i == 5'h07 && d[0] && b[0]) mdl_reset();
		else if (mask(i) != 0) mdl[i] = ((mdl[i] & ~bm) | (d & bm)) & mask(i);
	endtask

	// Every word read back, then every channel port compared with the shadow.
	task automatic check_all;
		logic [31:0] w, s;
		logic [1:0]  st;
		// Status: lock input, no tune pending, invalid divide where divided with code zero.
		s = {31'h0, lock};
		for (int g = 0; g < 5; g++) s[2+g] = mdl[g][12] && (mdl[g][7:0] == 0);
		for (int i = 0; i < 32; i++) begin
			ccoc_host_i.access(1'b0, 5'(i), 32'h00000000, 4'hf, w);
			chk(w, (i < 16) ? mdl[i] : (i == 16) ? s : 0, "word readback");
		end
		repeat (2) @(posedge clk);
		for (int g = 0; g < 5; g++) begin
			w = mdl[g];
			chk(div_c[8*g +: 8], w[7:0], "divide code");
			chk(dly_c[4*g +: 4], w[11:8], "delay code");
			chk(src[2*g +: 2], w[13:12], "source select");
			chk(swing[g], w[18], "swing select");
			chk(ps[12*g +: 12], w[13] ? 300 + 150 * w[11:8] : 0, "delay ps");
			chk(tdiv[9*g +: 9], w[12] ? 2 * w[7:0] : 1, "total divide");
			for (int p = 0; p < 2; p++) begin
				st = w[14+2*p +: 2];
				chk({oe[2*g+p], inv[2*g+p], low[2*g+p]}, {st != 3, st == 0, st == 2}, "pin decode");
			end
		end
		chk(fb, mdl[15][17:0], "feedback counter");
	endtask

	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		mdl_reset();
	endtask

	// Watchdog sized well beyond the few thousand cycles the run needs.
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		print_verdict();
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		do_reset();
		check_all();
		// Each pass covers one mux code, pin code and delay code; stride 7 visits all sixteen codes.
		for (int i = 0; i < 20; i++) begin
			r = nxt_rnd();
			r[13:12] = 2'(i);
			r[15:14] = 2'(i);
			r[17:16] = ~2'(i);
			r[11:8]  = 4'(i * 7);
			if (i == 1) r[7:0] = 8'h00;
			wr(5'(i % 5), r, 4'hf);
			check_all();
		end
		r = nxt_rnd();
		wr(5'h00, r, 4'h2);
		wr(5'h0c, r, 4'hf);
		wr(5'h07, 32'h00000000, 4'hf);
		check_all();
		// Tuning trigger: immediate, held for lock, released by lock or by clearing the bit.
		t0 = tunes;
		wr(5'h0a, 32'h00000000, 4'h1);
		wr(5'h0f, r, 4'hf);
		wr(5'h0f, r, 4'h8);
		repeat (3) @(posedge clk);
		chk(tunes, t0 + 1, "tune immediate");
		wr(5'h0a, 32'h00000001, 4'h1);
		wr(5'h0f, r, 4'h1);
		repeat (12) @(posedge clk);
		chk(tunes, t0 + 1, "tune held");
		lock <= 1'b1;
		repeat (8) @(posedge clk);
		chk(tunes, t0 + 2, "tune on lock");
		wr(5'h0a, 32'h00000000, 4'h1);
		ccoc_host_i.access(1'b0, 5'h10, 32'h00000000, 4'hf, r);
		chk(r[0], 1'b1, "lock status");
		@(posedge clk) lock <= 1'b0;
		wr(5'h0a, 32'h00000001, 4'h1);
		repeat (8) @(posedge clk);
		wr(5'h0f, r, 4'h2);
		repeat (10) @(posedge clk);
		chk(tunes, t0 + 2, "tune pending");
		ccoc_host_i.access(1'b0, 5'h10, 32'h00000000, 4'hf, r);
		chk(r[1], 1'b1, "pending status");
		wr(5'h0a, 32'h00000000, 4'h1);
		repeat (3) @(posedge clk);
		chk(tunes, t0 + 3, "tune on clear");
		wr(5'h07, 32'h00000001, 4'h1);
		check_all();
		do_reset();
		check_all();
		print_verdict();
	end
endmodule

`default_nettype wire
